// >>> hdl/io_pin_drive_and_interrupt.sv
`timescale 1ns/1ps
module io_pin_drive_and_interrupt
   import gpio_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [DATA_W-1:0] rdata,
   input wire logic [PINS-1:0] pin_in,
   input wire logic [PINS-1:0] fabric_out,
   input wire logic [AUX_OES-1:0] aux_oe,
   output pad_ctl_t pad,
   output logic [PINS-1:0] pin_sync_in,
   output logic irq
);
   // Port view registers, one bit per pin; lvttl is a single port bit, oe_sel four bits per pin.
   logic [PINS-1:0] pin_output_value;
   logic [PINS-1:0] dm0, dm1, dm2;
   logic [PINS-1:0] pin_edge_rate_cfg;
   logic [PINS-1:0] bypass;
   logic [PINS-1:0] bidir;
   logic [PINS-1:0] in_dis;
   logic [PINS-1:0] irq_m0, irq_m1;
   logic [PINS-1:0] status;
   logic [PINS-1:0] regulated;
   logic lvttl;
   logic [SEL_W-1:0] oe_sel [PINS];

   logic [PINS-1:0] dh, dl, rh, rl, eok, ien, hit, in_gated, val, oe;
   logic [PINS-1:0] clr_mask;
   logic [DATA_W-1:0] next_rdata;

   function automatic logic wr_at(input logic [ADDR_W-1:0] ofs);
      return wr && (addr == ofs);
   endfunction

   function automatic logic pin_at(input int p);
      return addr == OFS_PIN0 + ADDR_W'(p);
   endfunction

   function automatic logic sel_at(input int p);
      return addr == OFS_SEL0 + ADDR_W'(p);
   endfunction

   function automatic logic pin_wr(input int p);
      return wr && pin_at(p);
   endfunction

   // Port view writes and pin view writes land on the same bits.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_output_value <= '0;
      end else begin
         if (wr_at(OFS_OUT)) begin
            pin_output_value <= wdata;
         end
         for (int p = 0; p < PINS; p++) begin
            if (pin_wr(p)) begin
               pin_output_value[p] <= wdata[PF_OUT];
            end
         end
      end
   end

   // The three drive-mode planes together give each pin its mode.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dm0 <= '0;
      end else begin
         if (wr_at(OFS_DM0)) begin
            dm0 <= wdata;
         end
         for (int p = 0; p < PINS; p++) begin
            if (pin_wr(p)) begin
               dm0[p] <= wdata[PF_DM];
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dm1 <= '0;
      end else begin
         if (wr_at(OFS_DM1)) begin
            dm1 <= wdata;
         end
         for (int p = 0; p < PINS; p++) begin
            if (pin_wr(p)) begin
               dm1[p] <= wdata[PF_DM+1];
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dm2 <= '0;
      end else begin
         if (wr_at(OFS_DM2)) begin
            dm2 <= wdata;
         end
         for (int p = 0; p < PINS; p++) begin
            if (pin_wr(p)) begin
               dm2[p] <= wdata[PF_DM+2];
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_edge_rate_cfg <= '0;
      end else begin
         if (wr_at(OFS_SLOW)) begin
            pin_edge_rate_cfg <= wdata;
         end
         for (int p = 0; p < PINS; p++) begin
            if (pin_wr(p)) begin
               pin_edge_rate_cfg[p] <= wdata[PF_SLOW];
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bypass <= '0;
      end else begin
         if (wr_at(OFS_BYP)) begin
            bypass <= wdata;
         end
         for (int p = 0; p < PINS; p++) begin
            if (pin_wr(p)) begin
               bypass[p] <= wdata[PF_BYP];
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bidir <= '0;
      end else begin
         if (wr_at(OFS_BIDIR)) begin
            bidir <= wdata;
         end
         for (int p = 0; p < PINS; p++) begin
            if (pin_wr(p)) begin
               bidir[p] <= wdata[PF_BIDIR];
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         in_dis <= '0;
      end else begin
         if (wr_at(OFS_INDIS)) begin
            in_dis <= wdata;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_m0 <= '0;
      end else begin
         if (wr_at(OFS_IRQ0)) begin
            irq_m0 <= wdata;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_m1 <= '0;
      end else begin
         if (wr_at(OFS_IRQ1)) begin
            irq_m1 <= wdata;
         end
      end
   end

   // A regulated pin loses its resistive halves and floats there.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         regulated <= '0;
      end else begin
         if (wr_at(OFS_REG)) begin
            regulated <= wdata;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lvttl <= 1'b0;
      end else begin
         if (wr_at(OFS_CTL)) begin
            lvttl <= wdata[CTL_LVTTL];
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int p = 0; p < PINS; p++) begin
            oe_sel[p] <= '0;
         end
      end else begin
         for (int p = 0; p < PINS; p++) begin
            if (wr && sel_at(p)) begin
               oe_sel[p] <= wdata[SEL_W-1:0];
            end
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < PINS; g++) begin : pins
         assign val[g] = bypass[g] ? fabric_out[g] : pin_output_value[g];
         // With bidirectional set, a low enable makes the pin an input.
         assign oe[g] = bidir[g] ? aux_oe[oe_sel[g]] : 1'b1;
         pin_drive drv (
            .mode(drive_mode_t'({dm2[g], dm1[g], dm0[g]})),
            .value(val[g]),
            .oe(oe[g]),
            .regulated(regulated[g]),
            .in_dis(in_dis[g]),
            .drive_hi(dh[g]),
            .drive_lo(dl[g]),
            .res_hi(rh[g]),
            .res_lo(rl[g]),
            .edge_ok(eok[g]),
            .in_en(ien[g])
         );
         // Edge logic has no sleep gating; it sees the pin only while its input buffer is enabled.
         edge_detect det (
            .clk(clk),
            .rst(rst),
            .pin_in(in_gated[g]),
            .mode(irq_mode_t'({irq_m1[g], irq_m0[g]})),
            .hit(hit[g])
         );
      end
   endgenerate

   assign in_gated = pin_in & ien;

   // Pad controls are registered so the pins never see decode glitches.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pad <= '0;
      end else begin
         pad.drive_hi <= dh;
         pad.drive_lo <= dl;
         pad.res_hi <= rh;
         pad.res_lo <= rl;
         pad.slow <= pin_edge_rate_cfg & eok;
         pad.in_en <= ien;
         pad.lvttl <= lvttl;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_sync_in <= '0;
      end else begin
         pin_sync_in <= in_gated;
      end
   end

   // A read clears what it returned; a new hit in that cycle survives.
   assign clr_mask = (rd && addr == OFS_STAT) ? status : '0;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status <= '0;
      end else begin
         status <= (status & ~clr_mask) | hit;
      end
   end

   // The request follows the next status, so it rises with the bit.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |((status & ~clr_mask) | hit);
      end
   end

   // Unmapped addresses read zero; the input view ignores writes.
   always_comb begin
      next_rdata = '0;
      unique case (addr)
         OFS_OUT: next_rdata = pin_output_value;
         OFS_IN: next_rdata = in_gated;
         OFS_DM0: next_rdata = dm0;
         OFS_DM1: next_rdata = dm1;
         OFS_DM2: next_rdata = dm2;
         OFS_SLOW: next_rdata = pin_edge_rate_cfg;
         OFS_BYP: next_rdata = bypass;
         OFS_BIDIR: next_rdata = bidir;
         OFS_INDIS: next_rdata = in_dis;
         OFS_IRQ0: next_rdata = irq_m0;
         OFS_IRQ1: next_rdata = irq_m1;
         OFS_STAT: next_rdata = status;
         OFS_CTL: next_rdata[CTL_LVTTL] = lvttl;
         OFS_REG: next_rdata = regulated;
         default: begin
            for (int p = 0; p < PINS; p++) begin
               if (pin_at(p)) begin
                  next_rdata[PF_OUT] = pin_output_value[p];
                  next_rdata[PF_IN] = in_gated[p];
                  next_rdata[PF_DM] = dm0[p];
                  next_rdata[PF_DM+1] = dm1[p];
                  next_rdata[PF_DM+2] = dm2[p];
                  next_rdata[PF_SLOW] = pin_edge_rate_cfg[p];
                  next_rdata[PF_BYP] = bypass[p];
                  next_rdata[PF_BIDIR] = bidir[p];
               end
               if (sel_at(p)) begin
                  next_rdata[SEL_W-1:0] = oe_sel[p];
               end
            end
         end
      endcase
   end

   // Read data stand only in the cycle after the strobe.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= '0;
      end else begin
         rdata <= rd ? next_rdata : '0;
      end
   end
endmodule

// >>> hdl/gpio_pkg.sv
// Function
// - Three-bit drive mode per pin, eight modes.
// - Reset leaves pins analog high-Z, input off.
// - Digital high-Z: driver off, input on.
// - Single resistive modes: resistor one state, strong other.
// - No resistive modes on regulated special pins.
// - Open drain: high-Z one value, strong other.
// - Strong mode drives both levels strongly.
// - Combined resistive: always through a resistor.
// - Port view: one bit per pin.
// - Pin view aliases eight port bits per pin.
// - Bidirectional: output enable switches input/output drive.
// - Sixteen auxiliary output enables routable to pins.
// - Edge rate only in strong and open drain.
// - Edge rate held per pin in own register.
// - Eight pins feed one port interrupt request.
// - Per pin interrupt mode: rise, fall, both, none.
// - Detected event sets status bit, raises request.
// - Edge detection runs in every sleep mode.
// - No level-sensitive detection in this unit.
// - Port selects CMOS or LVTTL thresholds.
// - Per-pin input buffer disable in any mode.
package gpio_pkg;
   localparam int PINS = 8;
   localparam int AUX_OES = 16;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int SEL_W = 4;

   typedef enum logic [2:0] {
      dm_analog_hiz, dm_digital_hiz, dm_res_up, dm_res_down,
      dm_od_low, dm_od_high, dm_strong, dm_res_both
   } drive_mode_t;

   typedef enum logic [1:0] {
      irq_none, irq_rise, irq_fall, irq_both
   } irq_mode_t;

   localparam logic [ADDR_W-1:0] OFS_OUT = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_IN = 8'h01;
   localparam logic [ADDR_W-1:0] OFS_DM0 = 8'h02;
   localparam logic [ADDR_W-1:0] OFS_DM1 = 8'h03;
   localparam logic [ADDR_W-1:0] OFS_DM2 = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_SLOW = 8'h05;
   localparam logic [ADDR_W-1:0] OFS_BYP = 8'h06;
   localparam logic [ADDR_W-1:0] OFS_BIDIR = 8'h07;
   localparam logic [ADDR_W-1:0] OFS_INDIS = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_IRQ0 = 8'h09;
   localparam logic [ADDR_W-1:0] OFS_IRQ1 = 8'h0a;
   localparam logic [ADDR_W-1:0] OFS_STAT = 8'h0b;
   localparam logic [ADDR_W-1:0] OFS_CTL = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_REG = 8'h0d;
   localparam logic [ADDR_W-1:0] OFS_PIN0 = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_SEL0 = 8'h20;

   // Pin view fields: out, in (read-only), dm[2:0], slow, bypass, bidir.
   localparam int PF_OUT = 0;
   localparam int PF_IN = 1;
   localparam int PF_DM = 2;
   localparam int PF_SLOW = 5;
   localparam int PF_BYP = 6;
   localparam int PF_BIDIR = 7;
   localparam int CTL_LVTTL = 0;

   typedef struct packed {
      logic [PINS-1:0] drive_hi;
      logic [PINS-1:0] drive_lo;
      logic [PINS-1:0] res_hi;
      logic [PINS-1:0] res_lo;
      logic [PINS-1:0] slow;
      logic [PINS-1:0] in_en;
      logic lvttl;
   } pad_ctl_t;
endpackage

// >>> hdl/pin_drive.sv
`timescale 1ns/1ps
module pin_drive
   import gpio_pkg::*;
(
   input wire drive_mode_t mode,
   input wire logic value,
   input wire logic oe,
   input wire logic regulated,
   input wire logic in_dis,
   output logic drive_hi,
   output logic drive_lo,
   output logic res_hi,
   output logic res_lo,
   output logic edge_ok,
   output logic in_en
);
   drive_mode_t eff;

   always_comb begin
      eff = oe ? mode : dm_digital_hiz;
      drive_hi = 1'b0;
      drive_lo = 1'b0;
      res_hi = 1'b0;
      res_lo = 1'b0;
      unique case (eff)
         dm_analog_hiz, dm_digital_hiz: begin
         end
         dm_res_up: begin
            res_hi = value & ~regulated;
            drive_lo = ~value;
         end
         dm_res_down: begin
            drive_hi = value;
            res_lo = ~value & ~regulated;
         end
         dm_od_low: drive_lo = ~value;
         dm_od_high: drive_hi = value;
         dm_strong: begin
            drive_hi = value;
            drive_lo = ~value;
         end
         dm_res_both: begin
            res_hi = value & ~regulated;
            res_lo = ~value & ~regulated;
         end
      endcase
      edge_ok = (eff == dm_od_low) || (eff == dm_od_high) ||
         (eff == dm_strong);
      in_en = (eff != dm_analog_hiz) && !in_dis;
   end
endmodule

// >>> hdl/edge_detect.sv
`timescale 1ns/1ps
module edge_detect
   import gpio_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic pin_in,
   input wire irq_mode_t mode,
   output logic hit
);
   logic prev;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev <= 1'b0;
      end else begin
         prev <= pin_in;
      end
   end

   // Only transitions count; a steady level never fires.
   always_comb begin
      unique case (mode)
         irq_none: hit = 1'b0;
         irq_rise: hit = pin_in & ~prev;
         irq_fall: hit = ~pin_in & prev;
         irq_both: hit = pin_in ^ prev;
      endcase
   end
endmodule

// >>> sim/io_pin_checker.sv
`timescale 1ns/1ps
module io_pin_checker
   import gpio_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic rd,
   input wire logic [DATA_W-1:0] rdata,
   input wire pad_ctl_t pad,
   input wire logic [PINS-1:0] pin_sync_in,
   input wire logic irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   logic stat_rd;
   assign stat_rd = rd && addr == OFS_STAT;
   sequence s_read_hit;
      stat_rd ##1 rdata != '0;
   endsequence
   a_reset_pads_off: assert property ($fell(rst) |-> pad == '0)
      else $error("pad active right after reset");
   a_strong_excl: assert property ((pad.drive_hi & pad.drive_lo) == '0)
      else $error("strong high and low together");
   a_res_excl: assert property (((pad.drive_hi | pad.drive_lo) &
      (pad.res_hi | pad.res_lo)) == '0)
      else $error("strong and resistive drive together");
   a_slow_gated: assert property ((pad.slow &
      (pad.res_hi | pad.res_lo)) == '0)
      else $error("slow edge in resistive mode");
   a_sync_gated: assert property ((pin_sync_in & ~pad.in_en &
      ~$past(pad.in_en)) == '0)
      else $error("input seen with buffer off");
   a_irq_on_status: assert property (s_read_hit |-> $past(irq))
      else $error("status set without request");
   a_irq_drop: assert property ($fell(irq) |->
      $past(stat_rd) || $past(stat_rd, 2))
      else $error("request dropped without status read");
   a_unmapped_zero: assert property ($past(rd) && $past(addr) >= 8'h28
      |-> rdata == '0)
      else $error("unmapped read not zero");
   a_rdata_idle: assert property (!$past(rd) |-> rdata == '0)
      else $error("read data outside read cycle");
endmodule

// >>> sim/pin_load.sv
`timescale 1ns/1ps
module pin_load
   import gpio_pkg::*;
(
   input wire logic clk,
   input wire pad_ctl_t pad,
   input wire logic [PINS-1:0] ext_en,
   input wire logic [PINS-1:0] ext_val,
   output logic [PINS-1:0] level
);
   logic [PINS-1:0] drift = '0;
   // A pin nobody drives wanders, so it never holds its last level.
   always @(posedge clk) drift <= ~drift;
   always_comb begin
      level = (drift & ~pad.res_lo) | pad.res_hi;
      level = (ext_en & ext_val) | (~ext_en & level);
      level = (level | pad.drive_hi) & ~pad.drive_lo;
   end
endmodule

// >>> sim/io_pin_drive_and_interrupt_tb.sv
`timescale 1ns/1ps
module io_pin_drive_and_interrupt_tb
   import gpio_pkg::*;
;
   typedef struct packed {
      logic [2:0] m;
      logic [39:0] exp;
   } row_t;
   row_t rows [8] = '{'{3'h0, 40'h0}, '{3'h1, 40'h0},
      '{3'h2, 40'h00f00f0000}, '{3'h3, 40'h0f0000f000},
      '{3'h4, 40'h00f00000ff}, '{3'h5, 40'h0f000000ff},
      '{3'h6, 40'h0ff00000ff}, '{3'h7, 40'h00000ff000}};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic [PINS-1:0] fabric_out = '0;
   logic [AUX_OES-1:0] aux_oe = '0;
   logic [PINS-1:0] ext_en = '0;
   logic [PINS-1:0] ext_val = '0;
   logic [PINS-1:0] lvl;
   logic [PINS-1:0] pin_sync_in;
   logic irq;
   pad_ctl_t pad;
   int n_fail = 0;
   int n_tests = 0;
   io_pin_drive_and_interrupt i_io_pin_drive_and_interrupt (
      .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .pin_in(lvl), .fabric_out(fabric_out),
      .aux_oe(aux_oe), .pad(pad), .pin_sync_in(pin_sync_in), .irq(irq)
   );
   pin_load i_pin_load (
      .clk(clk), .pad(pad), .ext_en(ext_en), .ext_val(ext_val),
      .level(lvl)
   );
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic report_and_stop();
      $display("tests=%0d fails=%0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, v);
   endtask
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic wait_irq();
      for (int k = 0; k < 20 && irq !== 1'b1; k++) @(posedge clk);
      #1 chk(irq, 1'b1);
   endtask
   initial begin
      #100000 n_fail++;
      report_and_stop();
   end
   initial begin
      repeat (11) @(posedge clk);
      #1 chk(pad, '0);
      @(posedge clk);
      rst <= 1'b0;
      rchk(OFS_DM0, 8'h00);
      wr_reg(8'h30, 8'hff);
      rchk(8'h30, 8'h00);
      wr_reg(OFS_OUT, 8'h0f);
      wr_reg(OFS_SLOW, 8'hff);
      foreach (rows[i]) begin
         wr_reg(OFS_DM0, {8{rows[i].m[0]}});
         wr_reg(OFS_DM1, {8{rows[i].m[1]}});
         wr_reg(OFS_DM2, {8{rows[i].m[2]}});
         settle();
         chk(pad, {rows[i].exp, {8{rows[i].m != 3'h0}}, 1'b0});
      end
      wr_reg(OFS_PIN0 | 8'h02, 8'h39);
      rchk(OFS_DM0, 8'hfb);
      rchk(OFS_PIN0 | 8'h05, 8'h3c);
      wr_reg(OFS_REG, 8'hff);
      settle();
      chk({pad.res_hi, pad.res_lo}, 16'h0000);
      wr_reg(OFS_REG, 8'h00);
      wr_reg(OFS_DM0, 8'h00);
      wr_reg(OFS_BYP, 8'hff);
      fabric_out <= 8'ha5;
      wr_reg(OFS_SEL0, 8'h03);
      wr_reg(OFS_BIDIR, 8'h01);
      settle();
      chk({pad.drive_hi, pad.drive_lo}, 16'ha45a);
      @(posedge clk);
      aux_oe <= 16'h0008;
      settle();
      chk({pad.drive_hi, pad.drive_lo}, 16'ha55a);
      wr_reg(OFS_CTL, 8'h01);
      wr_reg(OFS_INDIS, 8'h01);
      settle();
      chk({pad.lvttl, pad.in_en, pin_sync_in[0]}, 10'h3fc);
      @(posedge clk);
      ext_en <= 8'hff;
      wr_reg(OFS_DM1, 8'h00);
      wr_reg(OFS_DM2, 8'h00);
      wr_reg(OFS_DM0, 8'hff);
      wr_reg(OFS_INDIS, 8'h00);
      wr_reg(OFS_IRQ0, 8'h05);
      wr_reg(OFS_IRQ1, 8'h06);
      settle();
      rchk(OFS_STAT, 8'h00);
      @(posedge clk);
      ext_val <= 8'h0f;
      wait_irq();
      rchk(OFS_STAT, 8'h05);
      settle();
      chk(irq, 1'b0);
      rchk(OFS_STAT, 8'h00);
      @(posedge clk);
      ext_val <= 8'h00;
      wait_irq();
      rchk(OFS_STAT, 8'h06);
      @(posedge clk);
      rst <= 1'b1;
      settle();
      chk(pad, '0);
      report_and_stop();
   end
endmodule
bind io_pin_drive_and_interrupt io_pin_checker i_io_pin_checker (
   .clk(clk), .rst(rst), .addr(addr), .rd(rd), .rdata(rdata),
   .pad(pad), .pin_sync_in(pin_sync_in), .irq(irq)
);
